/* File: core/input_monitor.v */
`timescale 1ns/1ps
module input_monitor #(
   parameter N = 8
) (
   // Clock and reset
   input  wire         sys_clk_i,
   input  wire         resetn_i,
   // Pins and control
   input  wire [N-1:0] din_i,
   input  wire [N-1:0] ptr_i,
   input  wire [N-1:0] ntr_i,
   input  wire         clr_i,
   // Status
   output wire [N-1:0] cond_o,
   output wire [N-1:0] event_o
);
   reg [N-1:0] meta_ff;
   reg [N-1:0] sync_ff;
   reg [N-1:0] prev_ff;
   reg [N-1:0] event_ff;
   reg [1:0]   prime_ff;
   wire [N-1:0] edge_w;

   assign cond_o  = sync_ff;
   assign event_o = event_ff;
   // Sampled every clock, far above the minimum rate       see R18
   assign edge_w = (sync_ff & ~prev_ff & ptr_i) |
                   (~sync_ff & prev_ff & ntr_i);

   // Edges are ignored until the synchroniser holds real samples
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_ff  <= {N{1'b0}};
         sync_ff  <= {N{1'b0}};
         prev_ff  <= {N{1'b0}};
         event_ff <= {N{1'b0}};
         prime_ff <= 2'h0;
      end else begin
         meta_ff  <= din_i;
         sync_ff  <= meta_ff;
         prev_ff  <= sync_ff;
         prime_ff <= {prime_ff[0], 1'b1};
         // A new edge wins over the read clear          see R17
         event_ff <= (clr_i ? {N{1'b0}} : event_ff) |
                     (prime_ff[1] ? edge_w : {N{1'b0}});
      end
   end
endmodule // input_monitor

/* File: core/pulse_channel.v */
`timescale 1ns/1ps
module pulse_channel #(
   parameter WW = 15
) (
   // Clock and reset
   input  wire          sys_clk_i,
   input  wire          resetn_i,
   // Control
   input  wire          tick_i,
   input  wire          start_i,
   input  wire [WW-1:0] width_i,
   output wire          active_o
);
   reg [WW-1:0] cnt_ff;
   reg          act_ff;

   assign active_o = act_ff;

   // Restart on a new pulse so a repeated command stretches it
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= {WW{1'b0}};
         act_ff <= 1'b0;
      end else if (start_i) begin
         cnt_ff <= width_i;
         act_ff <= 1'b1;                          // see R22
      end else if (act_ff && tick_i) begin
         if (cnt_ff <= {{(WW-1){1'b0}}, 1'b1}) begin
            act_ff <= 1'b0;                       // see R22
         end
         cnt_ff <= cnt_ff - {{(WW-1){1'b0}}, 1'b1};
      end
   end
endmodule // pulse_channel

/* File: core/relay_ctrl_defs.vh */
// Contract
// R1: Close or open each of sixteen outputs
// R2: Unnamed outputs keep their previous state
// R3: Channel lists act on several outputs together
// R4: Scan table defines single or multi-pole scanner
// R5: Immediate initiate homes relays, enables scanner
// R6: Continuous initiate enables or disables; default off
// R7: Each trigger advances enabled scanner one step
// R8: Break old position before making next one
// R9: Trigger at last position returns home
// R10: Scan table limit sixteen relays, 32 steps
// R11: Unscanned outputs stay under ordinary command control
// R12: Save zero writes scan list to storage
// R13: Setup, enables, mode, address set by commands
// R14: Saved configuration recalled at power-up
// R15: Input changes can raise a service request
// R16: Mandatory common commands answered correctly
// R17: Event register latches changes, clears on read
// R18: Rise and fall masks; sampled above 1 kHz
// R19: Enable bits summarise events into status byte
// R20: Outputs held off until configuration loaded
// R21: Triggers ignored while scanner disabled
// R22: Pulse closes output, reopens after width
`ifndef RELAY_CTRL_DEFS_VH
`define RELAY_CTRL_DEFS_VH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define OP_CLOSE      5'h01
`define OP_OPEN       5'h02
`define OP_PULSE      5'h03
`define OP_OPEN_ALL   5'h04
`define OP_PULSE_WID  5'h05
`define OP_SCAN_CLR   5'h06
`define OP_SCAN_STEP  5'h07
`define OP_INIT_IMM   5'h08
`define OP_INIT_CONT  5'h09
`define OP_TRG        5'h0A
`define OP_SAVE       5'h0B
`define OP_SET_ADDR   5'h0C
`define OP_SET_QEN    5'h0D
`define OP_SET_PTR    5'h0E
`define OP_SET_NTR    5'h0F
`define OP_SET_SRE    5'h10
`define OP_SET_ESE    5'h11
`define OP_CLS        5'h12
`define OP_RST        5'h13
`define OP_OPC        5'h14
`define OP_WAI        5'h15
`define OP_QUERY      5'h16

// ----------------------------------------------------------------
// Query selectors (cmd_arg_i[3:0] of OP_QUERY)
// ----------------------------------------------------------------
`define Q_RELAYS      4'h0
`define Q_COND        4'h1
`define Q_EVENT       4'h2
`define Q_STB         4'h3
`define Q_ESR         4'h4
`define Q_IDN         4'h5
`define Q_TST         4'h6
`define Q_OPC         4'h7
`define Q_ADDR        4'h8
`define Q_PW          4'h9
`define Q_QEN         4'hA
`define Q_PTR         4'hB
`define Q_NTR         4'hC
`define Q_SRE         4'hD
`define Q_ESE         4'hE
`define Q_POS         4'hF

// ----------------------------------------------------------------
// Status bits, limits, defaults
// ----------------------------------------------------------------
`define ESR_OPC       0
`define ESR_EXE       4
`define ESR_CME       5
`define STB_QSB       3
`define STB_ESB       5
`define STB_RQS       6
`define SCAN_STEPS    6'h20
`define PW_DEFAULT    15'h0019
`define PW_MAX        15'h7530
`define ADDR_MAX      5'h1E
`define ADDR_DEFAULT  5'h0A
`define PW_UNIT_MS    1
`define CLK_HZ        40000000
`define BBM_CYCLES    8'h04

// ----------------------------------------------------------------
// Storage word map
// ----------------------------------------------------------------
`define NV_CFG        6'h00
`define NV_PW         6'h01
`define NV_MASKS      6'h02
`define NV_ENABLES    6'h03
`define NV_TBL_BASE   6'h04
`define NV_LAST       6'h23

`endif

/* File: core/relay_scan_ctrl.v */
`timescale 1ns/1ps
`include "relay_ctrl_defs.vh"
module relay_scan_ctrl #(
   parameter NCH      = 16,
   parameter NIN      = 8,
   parameter TICK_CYC = `CLK_HZ / 1000 * `PW_UNIT_MS,
   parameter ID_CODE  = 16'h5A01   // Arbitrary identification value
) (
   // Clock and reset
   input  wire            sys_clk_i,
   input  wire            resetn_i,
   // Decoded command port
   input  wire            cmd_valid_i,
   input  wire [4:0]      cmd_op_i,
   input  wire [NCH-1:0]  cmd_list_i,
   input  wire [15:0]     cmd_arg_i,
   output wire            cmd_ready_o,
   output wire            rsp_valid_o,
   output wire [15:0]     rsp_data_o,
   // Bus events and status
   input  wire            get_i,
   output wire            srq_o,
   output wire [4:0]      bus_addr_o,
   // Non-volatile storage
   output wire            nvm_req_o,
   output wire            nvm_we_o,
   output wire [5:0]      nvm_addr_o,
   output wire [15:0]     nvm_wdata_o,
   input  wire            nvm_ack_i,
   input  wire [15:0]     nvm_rdata_i,
   // Relay outputs and digital inputs
   output wire [NCH-1:0]  relay_o,
   output wire            relay_en_o,
   input  wire [NIN-1:0]  din_i
);
   localparam S_RECALL = 3'h0;
   localparam S_IDLE   = 3'h1;
   localparam S_SAVE   = 3'h2;
   localparam S_BREAK  = 3'h3;
   localparam S_MAKE   = 3'h4;

   reg [2:0]     state_ff;
   reg [5:0]     nv_ptr_ff;
   reg           nvm_req_ff;
   reg           nvm_we_ff;
   reg [5:0]     nvm_addr_ff;
   reg [15:0]    nvm_wdata_ff;
   reg [NCH-1:0] relay_ff;
   reg [NCH-1:0] out_ff;
   reg           rly_en_ff;
   reg [NCH-1:0] scan_tbl [0:31];
   reg [5:0]     scan_len_ff;
   reg [4:0]     pos_ff;
   reg           scan_on_ff;
   reg           trg_pend_ff;
   reg [7:0]     bbm_cnt_ff;
   reg [14:0]    pw_ff;
   reg [4:0]     addr_ff;
   reg [NIN-1:0] ptr_ff;
   reg [NIN-1:0] ntr_ff;
   reg [NIN-1:0] qen_ff;
   reg [7:0]     sre_ff;
   reg [7:0]     ese_ff;
   reg [7:0]     esr_ff;
   reg           rsp_valid_ff;
   reg [15:0]    rsp_data_ff;
   reg           srq_ff;
   reg           ready_ff;
   reg [15:0]    tick_cnt_ff;
   reg           tick_ff;
   reg [NCH-1:0] scan_mask;
   reg [15:0]    nxt_wdata;
   reg [15:0]    nxt_rsp;
   integer       i;

   wire [NIN-1:0] cond_w;
   wire [NIN-1:0] event_w;
   wire [NCH-1:0] pulse_act_w;
   wire           take     = cmd_valid_i & ready_ff;
   wire           is_query = take && (cmd_op_i == `OP_QUERY);
   wire [3:0]     qsel     = cmd_arg_i[3:0];
   wire [NCH-1:0] pulse_go = (take && cmd_op_i == `OP_PULSE) ?
                             cmd_list_i : {NCH{1'b0}};
   wire           evt_clr  = (is_query && qsel == `Q_EVENT) ||
                             (take && cmd_op_i == `OP_CLS);
   wire [4:0]     nxt_pos  = ({1'b0, pos_ff} + 6'h01 == scan_len_ff) ?
                             5'h00 : pos_ff + 5'h01;              // see R9
   wire           qsb      = |(event_w & qen_ff);                 // see R19
   wire           esb      = |(esr_ff & ese_ff);
   wire [7:0]     stb_lo   = {2'b00, esb, 1'b0, qsb, 3'b000};
   wire           rqs      = |(stb_lo & sre_ff);                  // see R15
   wire [7:0]     stb      = {1'b0, rqs, esb, 1'b0, qsb, 3'b000};

   assign cmd_ready_o = ready_ff;
   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_data_o  = rsp_data_ff;
   assign srq_o       = srq_ff;
   assign bus_addr_o  = addr_ff;
   assign nvm_req_o   = nvm_req_ff;
   assign nvm_we_o    = nvm_we_ff;
   assign nvm_addr_o  = nvm_addr_ff;
   assign nvm_wdata_o = nvm_wdata_ff;
   assign relay_o     = out_ff;
   assign relay_en_o  = rly_en_ff;

   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   input_monitor #(.N(NIN)) u_mon (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .din_i     (din_i),
      .ptr_i     (ptr_ff),
      .ntr_i     (ntr_ff),
      .clr_i     (evt_clr),
      .cond_o    (cond_w),
      .event_o   (event_w)
   );

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_pulse
         pulse_channel #(.WW(15)) u_pc (
            .sys_clk_i (sys_clk_i),
            .resetn_i  (resetn_i),
            .tick_i    (tick_ff),
            .start_i   (pulse_go[g]),
            .width_i   (pw_ff),
            .active_o  (pulse_act_w[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Combinational helpers
   // ----------------------------------------------------------------
   // Relays owned by the scanner, all steps and poles together
   always @* begin
      scan_mask = {NCH{1'b0}};
      for (i = 0; i < 32; i = i + 1) begin
         if (i < scan_len_ff) begin
            scan_mask = scan_mask | scan_tbl[i];
         end
      end
   end

   always @* begin
      nxt_wdata = scan_tbl[nv_ptr_ff[4:0] - 5'h04];
      case (nv_ptr_ff)
         `NV_CFG:     nxt_wdata = {5'h00, addr_ff, scan_len_ff};
         `NV_PW:      nxt_wdata = {1'b0, pw_ff};
         `NV_MASKS:   nxt_wdata = {ptr_ff, ntr_ff};
         `NV_ENABLES: nxt_wdata = {qen_ff, sre_ff};
         default:     nxt_wdata = scan_tbl[nv_ptr_ff[4:0] - 5'h04];
      endcase
   end

   always @* begin
      case (qsel)                                                 // see R16
         `Q_RELAYS: nxt_rsp = relay_ff;
         `Q_COND:   nxt_rsp = {8'h00, cond_w};
         `Q_EVENT:  nxt_rsp = {8'h00, event_w};
         `Q_STB:    nxt_rsp = {8'h00, stb};
         `Q_ESR:    nxt_rsp = {8'h00, esr_ff};
         `Q_IDN:    nxt_rsp = ID_CODE;
         `Q_TST:    nxt_rsp = 16'h0000;
         `Q_OPC:    nxt_rsp = 16'h0001;
         `Q_ADDR:   nxt_rsp = {11'h000, addr_ff};
         `Q_PW:     nxt_rsp = {1'b0, pw_ff};
         `Q_QEN:    nxt_rsp = {8'h00, qen_ff};
         `Q_PTR:    nxt_rsp = {8'h00, ptr_ff};
         `Q_NTR:    nxt_rsp = {8'h00, ntr_ff};
         `Q_SRE:    nxt_rsp = {8'h00, sre_ff};
         `Q_ESE:    nxt_rsp = {8'h00, ese_ff};
         `Q_POS:    nxt_rsp = {10'h000, scan_on_ff, pos_ff};
         default:   nxt_rsp = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Pulse time base and output latches
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff     <= 1'b0;
         out_ff      <= {NCH{1'b0}};
         srq_ff      <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == TICK_CYC[15:0] - 16'h0001);
         if (tick_cnt_ff == TICK_CYC[15:0] - 16'h0001) begin
            tick_cnt_ff <= 16'h0000;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
         end
         // Held open until recall finishes                     see R20
         out_ff <= rly_en_ff ? (relay_ff | pulse_act_w) : {NCH{1'b0}};
         srq_ff <= rqs;
      end
   end

   // ----------------------------------------------------------------
   // Main controller
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff     <= S_RECALL;
         nv_ptr_ff    <= 6'h00;
         nvm_req_ff   <= 1'b0;
         nvm_we_ff    <= 1'b0;
         nvm_addr_ff  <= 6'h00;
         nvm_wdata_ff <= 16'h0000;
         relay_ff     <= {NCH{1'b0}};
         rly_en_ff    <= 1'b0;
         scan_len_ff  <= 6'h00;
         pos_ff       <= 5'h00;
         scan_on_ff   <= 1'b0;                                    // see R6
         trg_pend_ff  <= 1'b0;
         bbm_cnt_ff   <= 8'h00;
         pw_ff        <= `PW_DEFAULT;
         addr_ff      <= `ADDR_DEFAULT;
         ptr_ff       <= {NIN{1'b1}};
         ntr_ff       <= {NIN{1'b0}};
         qen_ff       <= {NIN{1'b0}};
         sre_ff       <= 8'h00;
         ese_ff       <= 8'h00;
         esr_ff       <= 8'h00;
         rsp_valid_ff <= 1'b0;
         rsp_data_ff  <= 16'h0000;
         ready_ff     <= 1'b0;
         for (i = 0; i < 32; i = i + 1) begin
            scan_tbl[i] <= {NCH{1'b0}};
         end
      end else begin
         rsp_valid_ff <= 1'b0;
         // Pulse leaves its output open once it ends          see R22
         relay_ff <= relay_ff & ~pulse_go;
         if (get_i) begin
            trg_pend_ff <= 1'b1;                                  // see R7
         end
         case (state_ff)
            S_RECALL: begin
               if (nvm_ack_i && nvm_req_ff) begin                 // see R14
                  nvm_req_ff <= 1'b0;
                  nv_ptr_ff  <= nv_ptr_ff + 6'h01;
                  case (nv_ptr_ff)
                     `NV_CFG: begin
                        addr_ff     <= nvm_rdata_i[10:6];
                        scan_len_ff <= (nvm_rdata_i[5:0] > `SCAN_STEPS) ?
                                       6'h00 : nvm_rdata_i[5:0];
                     end
                     `NV_PW:      pw_ff <= nvm_rdata_i[14:0];
                     `NV_MASKS:   {ptr_ff, ntr_ff} <= nvm_rdata_i;
                     `NV_ENABLES: {qen_ff, sre_ff} <= nvm_rdata_i;
                     default:
                        scan_tbl[nv_ptr_ff[4:0] - 5'h04] <= nvm_rdata_i;
                  endcase
                  if (nv_ptr_ff == `NV_LAST) begin
                     state_ff  <= S_IDLE;
                     rly_en_ff <= 1'b1;                           // see R20
                     ready_ff  <= 1'b1;
                  end
               end else if (!nvm_req_ff) begin
                  nvm_req_ff  <= 1'b1;
                  nvm_we_ff   <= 1'b0;
                  nvm_addr_ff <= nv_ptr_ff;
               end
            end
            S_SAVE: begin
               if (nvm_ack_i && nvm_req_ff) begin                 // see R12
                  nvm_req_ff <= 1'b0;
                  nv_ptr_ff  <= nv_ptr_ff + 6'h01;
                  if (nv_ptr_ff == `NV_LAST) begin
                     state_ff <= S_IDLE;
                     ready_ff <= 1'b1;
                  end
               end else if (!nvm_req_ff) begin
                  nvm_req_ff   <= 1'b1;
                  nvm_we_ff    <= 1'b1;
                  nvm_addr_ff  <= nv_ptr_ff;
                  nvm_wdata_ff <= nxt_wdata;
               end
            end
            S_BREAK: begin
               // Old position opened first                    see R8
               relay_ff   <= relay_ff & ~pulse_go & ~scan_tbl[pos_ff];
               bbm_cnt_ff <= `BBM_CYCLES;
               state_ff   <= S_MAKE;
            end
            S_MAKE: begin
               if (bbm_cnt_ff == 8'h00) begin
                  relay_ff <= (relay_ff & ~pulse_go) | scan_tbl[nxt_pos];
                  pos_ff   <= nxt_pos;
                  state_ff <= S_IDLE;
                  ready_ff <= 1'b1;
               end else begin
                  bbm_cnt_ff <= bbm_cnt_ff - 8'h01;
               end
            end
            S_IDLE: begin
               if (take) begin
                  case (cmd_op_i)
                     `OP_CLOSE:                            // see R1 R2 R3
                        relay_ff <= relay_ff | cmd_list_i;
                     `OP_OPEN:                             // see R1 R2 R3
                        relay_ff <= relay_ff & ~cmd_list_i;
                     `OP_PULSE: ;
                     `OP_OPEN_ALL: relay_ff <= {NCH{1'b0}};
                     `OP_PULSE_WID: begin
                        if (cmd_arg_i == 16'h0000 ||
                            cmd_arg_i > {1'b0, `PW_MAX}) begin
                           esr_ff[`ESR_EXE] <= 1'b1;
                        end else begin
                           pw_ff <= cmd_arg_i[14:0];              // see R13
                        end
                     end
                     `OP_SCAN_CLR: begin
                        scan_len_ff <= 6'h00;
                        scan_on_ff  <= 1'b0;
                        pos_ff      <= 5'h00;
                     end
                     `OP_SCAN_STEP: begin
                        if (scan_len_ff == `SCAN_STEPS) begin     // see R10
                           esr_ff[`ESR_EXE] <= 1'b1;
                        end else begin
                           scan_tbl[scan_len_ff[4:0]] <= cmd_list_i; // see R4
                           scan_len_ff <= scan_len_ff + 6'h01;
                           scan_on_ff  <= 1'b0;
                        end
                     end
                     `OP_INIT_IMM: begin
                        if (scan_len_ff == 6'h00) begin
                           esr_ff[`ESR_EXE] <= 1'b1;
                        end else begin
                           // Only scanner relays move           see R5 R11
                           relay_ff <= (relay_ff & ~scan_mask) | scan_tbl[0];
                           pos_ff      <= 5'h00;
                           scan_on_ff  <= 1'b1;
                           trg_pend_ff <= get_i;
                        end
                     end
                     `OP_INIT_CONT: scan_on_ff <= cmd_arg_i[0];   // see R6
                     `OP_TRG:       trg_pend_ff <= 1'b1;          // see R7
                     `OP_SAVE: begin
                        if (cmd_arg_i != 16'h0000) begin
                           esr_ff[`ESR_EXE] <= 1'b1;
                        end else begin
                           state_ff  <= S_SAVE;                   // see R12
                           nv_ptr_ff <= 6'h00;
                           ready_ff  <= 1'b0;
                        end
                     end
                     `OP_SET_ADDR: begin
                        if (cmd_arg_i > {11'h000, `ADDR_MAX}) begin
                           esr_ff[`ESR_EXE] <= 1'b1;
                        end else begin
                           addr_ff <= cmd_arg_i[4:0];             // see R13
                        end
                     end
                     `OP_SET_QEN: qen_ff <= cmd_arg_i[NIN-1:0];   // see R13
                     `OP_SET_PTR: ptr_ff <= cmd_arg_i[NIN-1:0];   // see R18
                     `OP_SET_NTR: ntr_ff <= cmd_arg_i[NIN-1:0];   // see R18
                     `OP_SET_SRE: sre_ff <= cmd_arg_i[7:0] & 8'hBF;
                     `OP_SET_ESE: ese_ff <= cmd_arg_i[7:0];
                     `OP_CLS:     esr_ff <= 8'h00;                // see R16
                     `OP_RST: begin                               // see R16
                        relay_ff    <= {NCH{1'b0}};
                        scan_on_ff  <= 1'b0;
                        pos_ff      <= 5'h00;
                        pw_ff       <= `PW_DEFAULT;
                        trg_pend_ff <= get_i;
                     end
                     `OP_OPC: esr_ff[`ESR_OPC] <= 1'b1;           // see R16
                     `OP_WAI: ;
                     `OP_QUERY: begin
                        rsp_valid_ff <= 1'b1;
                        rsp_data_ff  <= nxt_rsp;
                        if (qsel == `Q_ESR) begin
                           esr_ff <= 8'h00;
                        end
                     end
                     default: esr_ff[`ESR_CME] <= 1'b1;
                  endcase
               end else if (trg_pend_ff) begin
                  trg_pend_ff <= get_i;
                  // Disabled scanner drops the trigger          see R21
                  if (scan_on_ff && scan_len_ff != 6'h00) begin
                     state_ff <= S_BREAK;
                     ready_ff <= 1'b0;
                  end
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end
endmodule // relay_scan_ctrl

/* File: tb/nvm_model.sv */
`timescale 1ns/1ps
module nvm_model #(
   parameter DLY = 2
) (
   // Storage port
   input  wire        sys_clk_i,
   input  wire        req_i,
   input  wire        we_i,
   input  wire [5:0]  addr_i,
   input  wire [15:0] wdata_i,
   output reg         ack_o,
   output reg  [15:0] rdata_o
);
   reg [15:0] mem [0:63];
   integer    n;
   initial begin
      ack_o = 1'b0;
      rdata_o = 16'h0;
      for (n = 0; n < 64; n = n + 1)
         mem[n] = 16'h0;
      mem[0] = 16'h01C0;
      mem[1] = 16'h0002;
      mem[2] = 16'hFF00;
      mem[3] = 16'hFF08;
      n = 0;
   end
   // Toggles to catch a late read
   always @(posedge sys_clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         n = n + 1;
         if (n > DLY) begin
            n = 0;
            ack_o <= 1'b1;
            rdata_o <= mem[addr_i];
            if (we_i)
               mem[addr_i] <= wdata_i;
         end
      end
   end
endmodule // nvm_model

/* File: tb/relay_scan_ctrl_sva.sv */
`timescale 1ns/1ps
`include "relay_ctrl_defs.vh"
module relay_scan_ctrl_sva #(
   parameter NCH = 16
) (
   input wire           sys_clk_i, resetn_i, cmd_valid_i, cmd_ready_o,
   input wire           rsp_valid_o, nvm_ack_i, relay_en_o,
   input wire [4:0]     cmd_op_i, bus_addr_o,
   input wire [5:0]     nvm_addr_o,
   input wire [NCH-1:0] cmd_list_i, relay_o
);
   reg [NCH-1:0] l1_ff, l2_ff;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // List of the take two edges back
   always @(posedge sys_clk_i) begin
      l1_ff <= cmd_list_i;
      l2_ff <= l1_ff;
   end
   sequence s_take(op); cmd_valid_i && cmd_ready_o && cmd_op_i == op; endsequence
   property p_query; s_take(`OP_QUERY) |=> rsp_valid_o; endproperty
   a_query: assert property (p_query) else $error("no answer");
   property p_close; s_take(`OP_CLOSE) |-> ##2 (relay_o & l2_ff) == l2_ff;
   endproperty
   a_close: assert property (p_close) else $error("close lost");
   property p_keep; s_take(`OP_OPEN) |-> ##2 (relay_o & l2_ff) == 0 &&
      (relay_o & ~l2_ff) == ($past(relay_o) & ~l2_ff); endproperty
   a_keep: assert property (p_keep) else $error("open wrong");
   property p_pulse; s_take(`OP_PULSE) |-> ##2 (relay_o & l2_ff) == l2_ff;
   endproperty
   a_pulse: assert property (p_pulse) else $error("no pulse");
   property p_hold; !relay_en_o |-> relay_o == 0; endproperty
   a_hold: assert property (p_hold) else $error("early drive");
   property p_recall; $rose(relay_en_o) |->
      $past(nvm_ack_i) && $past(nvm_addr_o) == 6'h23; endproperty
   a_recall: assert property (p_recall) else $error("early on");
   property p_addr; bus_addr_o <= `ADDR_MAX; endproperty
   a_addr: assert property (p_addr) else $error("bad address");
   property p_bbm; (relay_o & ~$past(relay_o)) != 0 |->
      (~relay_o & $past(relay_o)) == 0; endproperty
   a_bbm: assert property (p_bbm) else $error("make with break");
endmodule // relay_scan_ctrl_sva
bind relay_scan_ctrl relay_scan_ctrl_sva #(.NCH(NCH)) chk_i (.*);

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "relay_ctrl_defs.vh"
module tb;
   reg         sys_clk_i = 1'b0, resetn_i = 1'b0, vld = 1'b0, get = 1'b0;
   reg  [4:0]  op = 5'h00;
   reg  [15:0] lst = 16'h0, arg = 16'h0, rsp;
   reg  [7:0]  din = 8'h00;
   wire        rdy, rv, srq, req, we, ack, en;
   wire [15:0] rd, wd, nrd, rly;
   wire [4:0]  adr;
   wire [5:0]  na;
   integer     failures = 0, checks = 0, cyc = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   relay_scan_ctrl #(.TICK_CYC(4), .ID_CODE(16'h1234)) relay_scan_ctrl_i (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_valid_i(vld),
      .cmd_op_i(op), .cmd_list_i(lst), .cmd_arg_i(arg), .cmd_ready_o(rdy),
      .rsp_valid_o(rv), .rsp_data_o(rd), .get_i(get), .srq_o(srq),
      .bus_addr_o(adr), .nvm_req_o(req), .nvm_we_o(we), .nvm_addr_o(na),
      .nvm_wdata_o(wd), .nvm_ack_i(ack), .nvm_rdata_i(nrd), .relay_o(rly),
      .relay_en_o(en), .din_i(din));
   nvm_model nvm_model_i (.sys_clk_i(sys_clk_i), .req_i(req), .we_i(we),
      .addr_i(na), .wdata_i(wd), .ack_o(ack), .rdata_o(nrd));
   task test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         test_done;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Held until taken
   task cmd(input [4:0] o, input [15:0] l, input [15:0] a);
      @(negedge sys_clk_i);
      vld = 1'b1;
      op = o;
      lst = l;
      arg = a;
      while (!rdy) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      vld = 1'b0;
      rsp = rd;
      @(negedge sys_clk_i);
   endtask
   task qry(input [3:0] s, input [15:0] e);
      cmd(`OP_QUERY, 16'h0, {12'h000, s});
      chk(rsp, e);
   endtask
   task trig(input [15:0] e);
      get = 1'b1;
      @(negedge sys_clk_i);
      get = 1'b0;
      repeat (12) @(negedge sys_clk_i);
      chk(rly, e);
   endtask
   task t_recall;
      while (!en) @(negedge sys_clk_i);
      chk(rly, 16'h0);
      chk({11'h000, adr}, 16'h0007);
      qry(4'h9, 16'h0002);
      qry(4'h5, 16'h1234);
      cmd(`OP_SET_ADDR, 16'h0, 16'h001F);
      qry(4'h4, 16'h0010);
   endtask
   task t_relay;
      cmd(`OP_CLOSE, 16'h7005, 16'h0);
      chk(rly, 16'h7005);
      cmd(`OP_OPEN, 16'h0004, 16'h0);
      chk(rly, 16'h7001);
      cmd(`OP_PULSE_WID, 16'h0, 16'h0003);
      cmd(`OP_PULSE, 16'h0100, 16'h0);
      chk(rly, 16'h7101);
      repeat (30) @(negedge sys_clk_i);
      chk(rly, 16'h7001);
   endtask
   task t_scan;
      cmd(`OP_SCAN_CLR, 16'h0, 16'h0);
      cmd(`OP_SCAN_STEP, 16'h0003, 16'h0);
      cmd(`OP_SCAN_STEP, 16'h000C, 16'h0);
      cmd(`OP_SCAN_STEP, 16'h0030, 16'h0);
      trig(16'h7001);
      cmd(`OP_INIT_IMM, 16'h0, 16'h0);
      chk(rly, 16'h7003);
      trig(16'h700C);
      trig(16'h7030);
      trig(16'h7003);
      cmd(`OP_INIT_CONT, 16'h0, 16'h0);
      trig(16'h7003);
      cmd(`OP_INIT_CONT, 16'h0, 16'h0001);
      trig(16'h700C);
   endtask
   task t_input;
      din = 8'h01;
      repeat (8) @(negedge sys_clk_i);
      chk({15'h0000, srq}, 16'h0001);
      qry(4'h2, 16'h0001);
      qry(4'h2, 16'h0);
      din = 8'h00;
      repeat (8) @(negedge sys_clk_i);
      qry(4'h2, 16'h0);
   endtask
   initial begin
      repeat (4) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      t_recall;
      t_relay;
      t_scan;
      t_input;
      cmd(`OP_SAVE, 16'h0, 16'h0);
      while (!rdy) @(negedge sys_clk_i);
      chk(nvm_model_i.mem[5], 16'h000C);
      test_done;
   end
endmodule // tb
